// ===== core/lpd_dimming_engine.sv
// PWM dimming engine: ramp, dither, counter/comparator, staggered outputs,
// combined current dimming and a persistent configuration store.
// Assumes one 100 MHz clock, synchronous active-low reset, AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module lpd_dimming_engine (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins and front end
    input  wire logic        pwm_in,
    input  wire logic [15:0] pin_duty,
    input  wire logic [4:0]  rate_set_resistor_code,
    // Sink and step-up control
    output logic [3:0]       led_en_q,
    output logic [7:0]       sink_level_q,
    output logic             level_resistor_use_q,
    output logic [10:0]      sink_margin_mv_q,
    output logic [4:0]       stepup_target_q,
    output logic [1:0]       stepup_switch_rate_q,
    output logic             stepup_start_q
);
    lpd_pkg::lpd_cfg_s cfg_q;
    logic [7:0]  store_q [lpd_pkg::CFG_BYTES];
    logic [63:0] store_flat;
    logic [15:0] brt_q;
    logic        en_q;
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q, rmux;
    logic [3:0]  wstrb_q;
    logic        pwm_m_q, pwm_s_q;
    logic [4:0]  rset_m_q, rset_s_q;

    // Index decode, bit 4 marks a mapped word
    function automatic logic [4:0] dec(input logic [7:0] a);
        return {(a[1:0] == 2'h0) && (a <= lpd_pkg::A_CTRL), a[5:2]};
    endfunction

    // Base resolution per rate code at the slowest clock
    function automatic logic [3:0] base_res(input logic [4:0] c);
        if (c == 5'h00) return 4'hD;
        else if (c <= 5'h03) return 4'hC;
        else if (c <= 5'h08) return 4'hB;
        else if (c <= 5'h18) return 4'hA;
        else if (c <= 5'h1B) return 4'h9;
        else return 4'h8;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register port

    logic       do_wr;
    logic [4:0] wd, rd;
    assign do_wr = !awready_q && !wready_q && !bvalid_q;
    assign wd    = dec(awaddr_q);
    assign rd    = dec(s_axi_araddr);

    // Address and data taken in either order; answer once both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= lpd_pkg::RESP_OK;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wd[4] ? lpd_pkg::RESP_OK : lpd_pkg::RESP_ERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= lpd_pkg::RESP_OK;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rmux;
            rresp_q   <= rd[4] ? lpd_pkg::RESP_OK : lpd_pkg::RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration front end and persistent store

    logic wr_cmd;
    assign wr_cmd = do_wr && wd[4] && wstrb_q[0] && wd[3:0] == lpd_pkg::A_CMD[5:2];

    // Store flattened for the load command
    for (genvar k = 0; k < lpd_pkg::CFG_BYTES; k++) begin : g_flat
        assign store_flat[k*8 +: 8] = store_q[k];
    end

    // Front-end writes act at once; load copies the store in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= lpd_pkg::CFG_RST;
        end else if (do_wr && wd[4] && wstrb_q[0] && !wd[3]) begin
            cfg_q[{wd[2:0], 3'h0} +: 8] <= wdata_q[7:0];
        end else if (wr_cmd && wdata_q[lpd_pkg::CMD_LOAD]) begin
            cfg_q <= store_flat;
        end
    end

    // Nonvolatile array: no reset, changed only by program command
    always_ff @(posedge aclk) begin
        if (wr_cmd && wdata_q[lpd_pkg::CMD_PROG]) begin
            for (int k = 0; k < lpd_pkg::CFG_BYTES; k++) begin
                store_q[k] <= cfg_q[k*8 +: 8];
            end
        end
    end

    // Brightness and backlight enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brt_q <= 16'h0000;
            en_q  <= 1'b0;
        end else if (do_wr && wd[4]) begin
            if (wd[3:0] == lpd_pkg::A_BRT[5:2]) begin
                if (wstrb_q[0]) brt_q[7:0] <= wdata_q[7:0];
                if (wstrb_q[1]) brt_q[15:8] <= wdata_q[15:8];
            end
            if (wd[3:0] == lpd_pkg::A_CTRL[5:2] && wstrb_q[0]) begin
                en_q <= wdata_q[lpd_pkg::CTRL_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_m_q  <= 1'b0;
            pwm_s_q  <= 1'b0;
            rset_m_q <= 5'h00;
            rset_s_q <= 5'h00;
        end else begin
            pwm_m_q  <= pwm_in;
            pwm_s_q  <= pwm_m_q;
            rset_m_q <= rate_set_resistor_code;
            rset_s_q <= rset_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Brightness ramp

    logic        direct, ramping;
    logic [15:0] tgt, ramp_q;
    logic [9:0]  rcnt_q, rint;
    assign direct  = cfg_q.src == lpd_pkg::SRC_DIRECT;
    assign tgt     = (cfg_q.src == lpd_pkg::SRC_REG) ? brt_q : pin_duty;
    assign ramping = ramp_q != tgt;
    assign rint    = 10'(cfg_q.ramp_time * lpd_pkg::RAMP_UNIT_CYC);

    // One LSB of 16 bits per interval, same pace up and down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_q <= 16'h0000;
            rcnt_q <= 10'h000;
        end else if (cfg_q.ramp_time == 4'h0 || direct) begin
            ramp_q <= tgt;
            rcnt_q <= 10'h000;
        end else if (!ramping) begin
            rcnt_q <= 10'h000;
        end else if (rcnt_q >= rint - 10'h001) begin
            rcnt_q <= 10'h000;
            ramp_q <= (ramp_q < tgt) ? ramp_q + 16'h0001 : ramp_q - 16'h0001;
        end else begin
            rcnt_q <= rcnt_q + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combined PWM and current dimming

    logic        below;
    logic [15:0] pwm_val, prod;
    logic [7:0]  cur_tgt;
    logic [11:0] ccnt_q, cint;
    assign below   = cfg_q.switch_50 ? !ramp_q[15] : ramp_q[15:14] == 2'h0;
    assign prod    = cfg_q.sink_code * ramp_q[15:8];
    assign cint    = 12'((cfg_q.cur_ramp_sel + 3'h1) * lpd_pkg::CURR_STEP_CYC);

    // Below the handover PWM scales to full; above it current follows
    always_comb begin
        pwm_val = ramp_q;
        cur_tgt = cfg_q.sink_code;
        if (cfg_q.combined_en) begin
            if (below) begin
                pwm_val = cfg_q.switch_50 ? 16'(ramp_q << 1) : 16'(ramp_q << 2);
                cur_tgt = cfg_q.switch_50 ? cfg_q.sink_code >> 1 : cfg_q.sink_code >> 2;
            end else begin
                pwm_val = 16'hFFFF;
                cur_tgt = prod[15:8];
            end
        end
    end

    // Sink level steps toward its target only in combined mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sink_level_q <= 8'h00;
            ccnt_q       <= 12'h000;
        end else if (!en_q) begin
            sink_level_q <= 8'h00;
            ccnt_q       <= 12'h000;
        end else if (!cfg_q.combined_en) begin
            sink_level_q <= cur_tgt;
        end else if (ccnt_q >= cint - 12'h001) begin
            ccnt_q <= 12'h000;
            if (sink_level_q < cur_tgt) sink_level_q <= sink_level_q + 8'h01;
            else if (sink_level_q > cur_tgt) sink_level_q <= sink_level_q - 8'h01;
        end else begin
            ccnt_q <= ccnt_q + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM clock, counter, dither and comparator

    logic [4:0]  code_eff, div, tcnt_q;
    logic [3:0]  res, res_raw;
    logic [12:0] mask, cnt_q;
    logic [13:0] full, duty_q;
    logic [31:0] sh;
    logic [2:0]  fr, pmask, pidx_q;
    logic        tick, wrap, dith_on, stretch;
    logic [3:0]  lead_d;

    assign code_eff = cfg_q.resistor_rate_enable ? rset_s_q : cfg_q.output_rate_code;
    assign div      = 5'(lpd_pkg::PWM_DIV >> cfg_q.pulse_clock_multiplier_short);
    assign res_raw  = base_res(code_eff) + {2'h0, cfg_q.pulse_clock_multiplier_short};
    assign res      = (res_raw > lpd_pkg::RES_MAX) ? lpd_pkg::RES_MAX : res_raw;
    assign mask     = 13'((14'h0001 << res) - 14'h0001);
    assign tick     = tcnt_q >= div - 5'h01;
    assign wrap     = tick && cnt_q == mask;
    assign full     = 14'(pwm_val >> (5'h10 - {1'b0, res}));
    assign sh       = {16'h0000, pwm_val} << res;
    assign fr       = sh[15:13] >> (2'h3 - cfg_q.frac_sel);
    assign pmask    = 3'((4'h1 << cfg_q.frac_sel) - 4'h1);
    assign dith_on  = ramping && cfg_q.ramp_time != 4'h0 && !direct
                      && cfg_q.frac_sel != 2'h0;
    assign stretch  = dith_on && (pidx_q & pmask) < fr;

    // Clock-rate enable and free-running counter, duty latched per period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcnt_q <= 5'h00;
            cnt_q  <= 13'h0000;
            duty_q <= 14'h0000;
            pidx_q <= 3'h0;
        end else begin
            tcnt_q <= tick ? 5'h00 : tcnt_q + 5'h01;
            if (tick) cnt_q <= (cnt_q + 13'h0001) & mask;
            if (wrap) begin
                duty_q <= full + {13'h0000, stretch};
                pidx_q <= pidx_q + 3'h1;
            end
        end
    end

    // With stagger on and not pass-through, output i compares a count shifted by i quarter periods
    for (genvar i = 0; i < 4; i++) begin : g_lead
        logic [12:0] off, ci;
        assign off = (cfg_q.staggered_outputs_enable && !direct)
                     ? 13'(13'(i) << (res - 4'h2)) : 13'h0000;
        assign ci  = (cnt_q - off) & mask;
        assign lead_d[i] = {1'b0, ci} < duty_q;
    end

    // Comparator drives the sinks; pass-through copies the sampled pin
    always_ff @(posedge aclk) begin
        if (!aresetn || !en_q) led_en_q <= 4'h0;
        else if (direct) led_en_q <= {4{pwm_s_q}};
        else led_en_q <= lead_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Step-up and sink configuration outputs

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_resistor_use_q <= 1'b0;
            sink_margin_mv_q     <= 11'h000;
            stepup_target_q      <= 5'h00;
            stepup_switch_rate_q <= 2'h0;
            stepup_start_q       <= 1'b0;
        end else begin
            level_resistor_use_q <= cfg_q.resistor_level_enable;
            sink_margin_mv_q     <= 11'(lpd_pkg::MARGIN_BASE_MV
                + lpd_pkg::STEPUP_STEP_MV * cfg_q.sink_margin_select);
            stepup_target_q      <= cfg_q.stepup_target_code;
            stepup_switch_rate_q <= cfg_q.stepup_switch_rate;
            stepup_start_q       <= en_q && cfg_q.stepup_en;
        end
    end

    // Read data selection
    always_comb begin
        rmux = 32'h0000_0000;
        if (!rd[3]) rmux[7:0] = cfg_q[{rd[2:0], 3'h0} +: 8];
        else if (rd[3:0] == lpd_pkg::A_BRT[5:2]) rmux[15:0] = brt_q;
        else if (rd[3:0] == lpd_pkg::A_STAT[5:2]) begin
            rmux[31:16] = ramp_q;
            rmux[lpd_pkg::ST_RAMP] = ramping;
            rmux[lpd_pkg::ST_DIRECT] = direct;
        end else if (rd[3:0] == lpd_pkg::A_CTRL[5:2]) rmux[lpd_pkg::CTRL_EN] = en_q;
        if (!rd[4]) rmux = 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    leds_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !en_q |=> led_en_q == 4'h0) else $error("leds on while disabled");
    pass_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && direct |=> led_en_q == {4{$past(pwm_s_q)}})
        else $error("pass-through mismatch");
    lead_same_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg_q.staggered_outputs_enable && !direct |=> led_en_q == 4'h0 || led_en_q == 4'hF)
        else $error("outputs not together");
    steady_dith_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap && (!ramping || cfg_q.ramp_time == 4'h0) |=> duty_q == $past(full))
        else $error("dither while steady");
    sink_reset_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> cfg_q.sink_code == 8'h7F) else $error("bad reset code");
    stretch_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dith_on && cfg_q.frac_sel == 2'h3 && fr == 3'h1 |-> stretch == (pidx_q == 3'h0))
        else $error("stretch rate wrong");
    stepup_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && cfg_q.stepup_en ##1 en_q && cfg_q.stepup_en |-> stepup_start_q)
        else $error("step-up not started");
    top_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
        code_eff == 5'h00 && cfg_q.pulse_clock_multiplier_short == 2'h0 |-> mask == 13'h1FFF)
        else $error("resolution not 13");
    ramp_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg_q.ramp_time == 4'h0 |=> ramp_q == $past(tgt)) else $error("ramp not instant");
endmodule // lpd_dimming_engine
`default_nettype wire

// ===== core/lpd_pkg.sv
// Constants, field layout and carrier types for the LED dimming engine.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register port.
package lpd_pkg;
    // Register byte addresses
    localparam logic [7:0]  A_CFG0 = 8'h00;
    localparam logic [7:0]  A_BRT  = 8'h20;
    localparam logic [7:0]  A_CMD  = 8'h24;
    localparam logic [7:0]  A_STAT = 8'h28;
    localparam logic [7:0]  A_CTRL = 8'h2C;
    // Bit positions and configuration byte count
    localparam int          CMD_LOAD  = 0;
    localparam int          CMD_PROG  = 1;
    localparam int          CTRL_EN   = 0;
    localparam int          ST_RAMP   = 0;
    localparam int          ST_DIRECT = 1;
    localparam int          CFG_BYTES = 8;
    // Reset values and answers
    localparam logic [63:0] CFG_RST  = 64'h0000_0000_0000_007F;
    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;
    // Timing
    localparam int SYS_MHZ       = 100;
    localparam int PWM_BASE_MHZ  = 5;
    localparam int PWM_DIV       = SYS_MHZ / PWM_BASE_MHZ;
    localparam int RAMP_FULL_MS  = 500;
    localparam int RAMP_CODES    = 15;
    localparam int RAMP_UNIT_CYC = RAMP_FULL_MS * 1000 * SYS_MHZ / RAMP_CODES / 65536;
    localparam int CURR_STEP_US  = 10;
    localparam int CURR_STEP_CYC = CURR_STEP_US * SYS_MHZ;
    // Resolution and margin
    localparam logic [3:0] RES_MAX        = 4'hD;
    localparam int         MARGIN_BASE_MV = 300;
    localparam int         STEPUP_STEP_MV = 125;

    typedef enum logic [1:0] {
        SRC_PIN_A  = 2'h0,
        SRC_PIN_B  = 2'h1,
        SRC_REG    = 2'h2,
        SRC_DIRECT = 2'h3
    } lpd_src_e;

    // Eight configuration bytes, byte 0 in the low bits
    typedef struct packed {
        logic [15:0] spare;
        logic [5:0]  rsv5;
        lpd_src_e    src;
        logic        rsv4;
        logic [1:0]  stepup_switch_rate;
        logic [4:0]  stepup_target_code;
        logic        stepup_en;
        logic [2:0]  sink_margin_select;
        logic [1:0]  cur_ramp_sel;
        logic        switch_50;
        logic        combined_en;
        logic        resistor_level_enable;
        logic        staggered_outputs_enable;
        logic [3:0]  ramp_time;
        logic [1:0]  frac_sel;
        logic        resistor_rate_enable;
        logic [1:0]  pulse_clock_multiplier_short;
        logic [4:0]  output_rate_code;
        logic [7:0]  sink_code;
    } lpd_cfg_s;
endpackage

// ===== testbench/lpd_dimming_engine_tb.sv
// Self-checking bench for the LED dimming engine.
// Assumes a 100 MHz clock and an AXI4-Lite master driven from here.
`timescale 1ns/1ps
`default_nettype none
module lpd_dimming_engine_tb;
    typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r; } lpd_row_s;
    localparam int PER = 256 * lpd_pkg::PWM_DIV;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, sink;
    logic [31:0] wdata = 32'h0000_0000, rdata, on_cycles, rdv;
    logic [3:0]  wstrb = 4'hF, led, lv;
    logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
    logic        arv = 1'h0, rready = 1'h0, pwm_in = 1'h0, clr = 1'h0, s;
    logic        awr, wrdy, bvalid, arr, rvalid, lvl_res, start;
    logic [1:0]  bresp, rresp, sw_rate, resp;
    logic [15:0] pin_duty = 16'h0000;
    logic [4:0]  rcode = 5'h00, target;
    logic [10:0] margin;
    int          n_errors = 0, tests_run = 0, n, load;
    lpd_row_s    rows [5] = '{'{8'h04, 32'h0000_001F, 32'h0000_001F, 2'h0},
        '{8'h1C, 32'h0000_00A5, 32'h0000_00A5, 2'h0}, '{8'h20, 32'h0000_1234, 32'h0000_1234, 2'h0},
        '{8'h24, 32'h0000_0000, 32'h0000_0000, 2'h0}, '{8'h30, 32'h0000_0055, 32'h0000_0000, 2'h2}};

    always #5 aclk = ~aclk;

    lpd_dimming_engine u_lpd_dimming_engine (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_in(pwm_in),
        .pin_duty(pin_duty), .rate_set_resistor_code(rcode), .led_en_q(led),
        .sink_level_q(sink), .level_resistor_use_q(lvl_res), .sink_margin_mv_q(margin),
        .stepup_target_q(target), .stepup_switch_rate_q(sw_rate), .stepup_start_q(start));

    lpd_sink_model u_lpd_sink_model (.aclk(aclk), .led_en_q(led), .sink_level_q(sink),
        .clr(clr), .on_cycles(on_cycles), .load_ua(load));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Bus cycles; no fixed latency assumed, only the bounded wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
            if (n > 100) begin chk("timeout", 32'h0000_0001, 32'h0000_0000); complete_run(); end
        end while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a);
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arr) arv <= 1'h0;
            if (n > 100) begin chk("timeout", 32'h0000_0001, 32'h0000_0000); complete_run(); end
        end while (!rvalid);
        rdv = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    // Settle one period, then count string 0 on-time over two periods
    task automatic duty(input logic [31:0] exp);
        s = 1'h1;
        repeat (PER) @(posedge aclk);
        clr <= 1'h1;
        @(posedge aclk);
        clr <= 1'h0;
        repeat (2 * PER) begin
            @(posedge aclk);
            if (led !== 4'h0 && led !== 4'hF) s = 1'h0;
        end
        #1;
        chk("on_time", on_cycles, exp);
        chk("outputs_together", 32'(s), 32'h0000_0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00);
        chk("sink_code_rst", rdv, 32'h0000_007F);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk("bresp", 32'(resp), 32'(rows[i].r));
            rd(rows[i].a);
            chk("rdata", rdv, rows[i].q);
            chk("rresp", 32'(resp), 32'(rows[i].r));
        end
        // Program the store, change the front end, then load the store back
        wr(8'h24, 32'h0000_0002);
        wr(8'h1C, 32'h0000_0000);
        rd(8'h1C);
        chk("front_end_now", rdv, 32'h0000_0000);
        wr(8'h24, 32'h0000_0001);
        rd(8'h1C);
        chk("store_load", rdv, 32'h0000_00A5);
        // Step-up and sink settings: margin 5, target 15h, rate 2, resistor on
        wr(8'h0C, 32'h0000_00D0);
        wr(8'h10, 32'h0000_0055);
        wr(8'h08, 32'h0000_0080);
        chk("sink_off", 32'(sink), 32'h0000_0000);
        wr(8'h2C, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        chk("stepup_start", 32'(start), 32'h0000_0001);
        chk("margin", 32'(margin), 32'(lpd_pkg::MARGIN_BASE_MV + lpd_pkg::STEPUP_STEP_MV * 5));
        chk("target", 32'(target), 32'h0000_0015);
        chk("switch_rate", 32'(sw_rate), 32'h0000_0002);
        chk("sink_level", 32'(sink), 32'h0000_007F);
        chk("level_res", 32'(lvl_res), 32'h0000_0001);
        // 8-bit resolution at rate code 1F, register source, quarter duty
        wr(8'h04, 32'h0000_001F);
        wr(8'h08, 32'h0000_0000);
        wr(8'h14, 32'h0000_0002);
        wr(8'h20, 32'h0000_4000);
        duty(32'(64 * lpd_pkg::PWM_DIV * 2));
        // Staggered outputs, each a quarter period behind the previous
        wr(8'h08, 32'h0000_0040);
        repeat (PER) @(posedge aclk);
        for (int i = 0; i < 16; i++) begin
            lv = led;
            repeat (PER / 4) @(posedge aclk);
            chk("stagger", 32'(led[3:1]), 32'(lv[2:0]));
            repeat (333) @(posedge aclk);
        end
        // Ramp of 256 LSB with dither on; must end steady without stretch
        wr(8'h08, 32'h0000_0007);
        wr(8'h20, 32'h0000_4100);
        rd(8'h28);
        chk("ramping", 32'(rdv[0]), 32'h0000_0001);
        for (int i = 0; i < 6000 && rdv[0] !== 1'h0; i++) rd(8'h28);
        chk("ramp_end", rdv, 32'h4100_0000);
        duty(32'(65 * lpd_pkg::PWM_DIV * 2));
        // Pass-through follows the pin on all outputs
        wr(8'h14, 32'h0000_0003);
        rd(8'h28);
        chk("direct", 32'(rdv[1]), 32'h0000_0001);
        pwm_in <= 1'h1;
        repeat (5) @(posedge aclk);
        chk("direct_hi", 32'(led), 32'h0000_000F);
        chk("load", 32'(load), 32'(30000 * 127 / 255 * 4));
        pwm_in <= 1'h0;
        repeat (5) @(posedge aclk);
        chk("direct_lo", 32'(led), 32'h0000_0000);
        // Combined dimming, 50% handover, rate from resistor, doubled clock
        wr(8'h08, 32'h0000_0000);
        wr(8'h14, 32'h0000_0002);
        wr(8'h00, 32'h0000_0004);
        rcode <= 5'h1F;
        wr(8'h04, 32'h0000_00A0);
        wr(8'h20, 32'h0000_4000);
        wr(8'h0C, 32'h0000_0003);
        repeat (1500) @(posedge aclk);
        chk("cur_step1", 32'(sink), 32'h0000_0003);
        repeat (1000) @(posedge aclk);
        chk("cur_step2", 32'(sink), 32'h0000_0002);
        duty(32'(PER));
        // Second reset in mid-run
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("led_rst", 32'(led), 32'h0000_0000);
        rd(8'h00);
        chk("sink_code_rst2", rdv, 32'h0000_007F);
        complete_run();
    end
endmodule // lpd_dimming_engine_tb
`default_nettype wire

// ===== testbench/lpd_sink_model.sv
// Model of the four LED string sinks on the far side of the engine.
// Assumes sink enables and the sink current code come from the dimming engine.
`timescale 1ns/1ps
`default_nettype none
module lpd_sink_model (
    // Clock
    input  wire logic        aclk,
    // Engine drive
    input  wire logic [3:0]  led_en_q,
    input  wire logic [7:0]  sink_level_q,
    input  wire logic        clr,
    // Observed load
    output logic [31:0]      on_cycles,
    output var int           load_ua
);
    ////////////////////////////////////////////////////////////////////////////
    // Load current in uA: each lit string draws the linear share of 30 mA
    assign load_ua = 30000 * int'(sink_level_q) / 255 * $countones(led_en_q);

    // On-time of string 0; sinks follow their enables with no delay of their own
    always_ff @(posedge aclk) begin
        if (clr)
            on_cycles <= 32'h0000_0000;
        else if (led_en_q[0])
            on_cycles <= on_cycles + 32'h0000_0001;
    end
endmodule // lpd_sink_model
`default_nettype wire
